// file: sim/urbt_remote.sv
// Remote serial partner: sends frames into the port, listens to its output
`timescale 1ns/100ps
`default_nettype none
module urbt_remote (
    input wire logic clk_in, // System clock
    input wire logic txd_in, // Port output
    output logic rxd_out, // Port input line
    output logic [7:0] caught_out // Last byte heard
);
    localparam int BIT_CLKS = 16; // Divisor 1
    logic [7:0] sh;
    initial rxd_out = 1'b1;
    initial caught_out = 8'h00;
    // ==========================================================
    // Start low, data LSB first, one stop of given level, then idle
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_in);
            rxd_out <= (i == 10) ? 1'b1 : fr[i];
            repeat (BIT_CLKS - 1) @(posedge clk_in);
        end
    endtask
    // ==========================================================
    // Listener samples mid-bit
    always begin
        @(negedge txd_in);
        repeat (BIT_CLKS / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_in);
            sh[i] = txd_in;
        end
        caught_out = sh;
        repeat (BIT_CLKS) @(posedge clk_in);
    end
endmodule // urbt_remote
`default_nettype wire

// file: sim/urbt_top_sva.sv
// Checker for bus, interrupt and timer relations of the serial port
`timescale 1ns/100ps
`default_nettype none
module urbt_top_sva
    import urbt_pkg::*;
(
    input wire logic core_clk_in, // Clock
    input wire logic rstn_in, // Reset
    input wire logic [7:0] addr_in, // Address
    input wire logic [7:0] wdata_in, // Write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    input wire logic [7:0] rdata_out, // Read data
    input wire logic rxd_in, // Serial in
    input wire logic txd_out, // Serial out
    input wire logic tx_irq_out, // Tx irq
    input wire logic rx_irq_out // Rx irq
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    logic [7:0] ctrl_ff;
    logic [7:0] div_ff;
    logic tmr;
    logic rd_dat;
    logic wr_zero;
    logic rd_ctl;
    logic rd_div;
    logic tmr4;
    assign tmr = ctrl_ff[CTL_TIMER] && ctrl_ff[7:6] == 2'b00;
    assign rd_ctl = rd_in && addr_in == OFF_CONTROL;
    assign rd_div = rd_in && addr_in == OFF_DIVISOR;
    assign tmr4 = tmr && div_ff == 8'h04;
    assign rd_dat = rd_in && addr_in == OFF_DATA;
    assign wr_zero = wr_in && addr_in == OFF_DATA && wdata_in == 8'h00;
    // ==========================================================
    // Shadow registers, so readback can be predicted
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_in && addr_in == OFF_CONTROL) begin
            ctrl_ff <= wdata_in;
        end
    end
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_ff <= DIVISOR_RESET;
        end else if (wr_in && addr_in == OFF_DIVISOR) begin
            div_ff <= wdata_in;
        end
    end
    // ==========================================================
    // Assertions
    AST_RDATA_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not idle");
    AST_CTRL_BACK: assert property (rd_ctl |=> rdata_out == ctrl_ff)
        else $error("control readback");
    AST_DIV_BACK: assert property (rd_div && !tmr |=> rdata_out == div_ff)
        else $error("divisor readback");
    AST_LIVE_COUNT: assert property (rd_div && tmr && div_ff != 8'h00
        |=> rdata_out != 8'h00 && rdata_out <= div_ff) else $error("live count range");
    AST_TIMER_IRQ: assert property (tmr4 && !rx_irq_out |-> ##[1:90] rx_irq_out)
        else $error("no timer reload irq");
    AST_TX_CLR: assert property (wr_zero |=> !tx_irq_out)
        else $error("tx irq not cleared");
    AST_TX_HOLD: assert property (tx_irq_out && !wr_zero |=> tx_irq_out)
        else $error("tx irq dropped");
    AST_RX_HOLD: assert property (rx_irq_out && !rd_dat |=> rx_irq_out)
        else $error("rx irq dropped");
    cover property (rd_dat && rx_irq_out);
    cover property ($rose(tx_irq_out));
    cover property (tmr && $rose(rx_irq_out));
endmodule // urbt_top_sva
`default_nettype wire

// file: sim/urbt_top_test.sv
// Testbench for the serial port block
`timescale 1ns/100ps
`default_nettype none
module urbt_top_test;
    import urbt_pkg::*;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rx;
        logic stop;
        logic [7:0] st;
        logic [7:0] data;
        logic irq;
    } urbt_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic rxd;
    logic txd;
    logic tx_irq;
    logic rx_irq;
    logic [7:0] caught;
    logic [7:0] v;
    int n;
    int fail_count = 0;
    int num_checks = 0;
    // Unmasked, masked, framing, parity error, odd parity, break, then receiver off
    // With parity on, the stop column is the parity bit and idle is the stop
    urbt_row_t rows [7] = '{
        '{8'h60, 8'h55, 1'b1, 8'h80, 8'h55, 1'b1},
        '{8'h40, 8'h3C, 1'b1, 8'h80, 8'h3C, 1'b0},
        '{8'h40, 8'hA3, 1'b0, 8'h90, 8'hA3, 1'b1},
        '{8'h50, 8'h01, 1'b0, 8'hC0, 8'h01, 1'b0},
        '{8'h58, 8'h01, 1'b0, 8'h80, 8'h01, 1'b0},
        '{8'h40, 8'h00, 1'b0, 8'h98, 8'h00, 1'b1},
        '{8'h00, 8'h55, 1'b1, 8'h00, 8'h00, 1'b0}};
    always #25 clk = ~clk;
    urbt_top i_dut (.core_clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rxd_in(rxd), .txd_out(txd),
        .tx_irq_out(tx_irq), .rx_irq_out(rx_irq));
    urbt_remote i_rem (.clk_in(clk), .txd_in(txd), .rxd_out(rxd), .caught_out(caught));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic wait_irq(input logic tx, input int lim);
        for (n = 0; (tx ? tx_irq : rx_irq) !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            if (n > lim) begin
                fail_count++;
                summarize();
            end
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(OFF_CONTROL);
        chk(v, 8'h00);
        rd_reg(OFF_DIVISOR);
        chk(v, 8'hFF);
        rd_reg(OFF_STATUS);
        chk(v, 8'h02);
        wr_reg(8'hF5, 8'h3C);
        rd_reg(8'hF5);
        chk(v, 8'h00);
        wr_reg(OFF_DIVISOR, 8'h01);
        $display("reset and map done");
        for (int i = 0; i < 7; i++) begin
            wr_reg(OFF_CONTROL, rows[i].ctrl);
            i_rem.send(rows[i].rx, rows[i].stop);
            chk({7'h00, rx_irq}, {7'h00, rows[i].irq});
            rd_reg(OFF_STATUS);
            chk(v & 8'hF8, rows[i].st);
            rd_reg(OFF_DATA);
            chk(v, rows[i].data);
            rd_reg(OFF_STATUS);
            chk(v & 8'hF8, 8'h00);
            chk({7'h00, rx_irq}, 8'h00);
            $display("row %0d done", i);
        end
        // Overrun: second byte lands on an unread one
        wr_reg(OFF_CONTROL, 8'h60);
        i_rem.send(8'h11, 1'b1);
        i_rem.send(8'h22, 1'b1);
        rd_reg(OFF_STATUS);
        chk(v & 8'hF8, 8'h80);
        rd_reg(OFF_DATA);
        chk(v, 8'h11);
        chk({7'h00, rx_irq}, 8'h01);
        rd_reg(OFF_STATUS);
        chk(v & 8'hF8, 8'hA0);
        rd_reg(OFF_DATA);
        rd_reg(OFF_STATUS);
        chk(v & 8'hF8, 8'h00);
        chk({7'h00, rx_irq}, 8'h00);
        $display("overrun done");
        // Transmit: zero write clears irq, next byte loaded mid-character
        wr_reg(OFF_CONTROL, 8'h80);
        wait_irq(1'b1, 40);
        wr_reg(OFF_DATA, 8'h00);
        rd_reg(OFF_STATUS);
        chk(v & 8'h04, 8'h00);
        chk({7'h00, tx_irq}, 8'h00);
        wait_irq(1'b1, 40);
        wr_reg(OFF_DATA, 8'hA5);
        repeat (400) @(posedge clk);
        chk(caught, 8'hA5);
        wr_reg(OFF_CONTROL, 8'h00);
        wr_reg(OFF_DATA, 8'h00);
        #1;
        chk({7'h00, tx_irq}, 8'h00);
        $display("transmit done");
        // Timer: reload every sixteen times four clocks
        wr_reg(OFF_DIVISOR, 8'h04);
        wr_reg(OFF_CONTROL, 8'h01);
        wait_irq(1'b0, 100);
        rd_reg(OFF_DIVISOR);
        chk({7'h00, v inside {[8'h01:8'h04]}}, 8'h01);
        rd_reg(OFF_DATA);
        chk({7'h00, rx_irq}, 8'h00);
        wait_irq(1'b0, 100);
        chk({7'h00, n inside {[54:64]}}, 8'h01);
        $display("timer done");
        summarize();
    end
endmodule // urbt_top_test
bind urbt_top urbt_top_sva i_chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .rxd_in(rxd_in), .txd_out(txd_out),
    .tx_irq_out(tx_irq_out), .rx_irq_out(rx_irq_out));
`default_nettype wire

// file: src/urbt_pkg.sv
// Package: register map, field positions, reset values and states of the serial port
package urbt_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_DATA = 8'hF1;
    localparam logic [7:0] OFF_STATUS = 8'hF2;
    localparam logic [7:0] OFF_CONTROL = 8'hF3;
    localparam logic [7:0] OFF_DIVISOR = 8'hF4;
    // ==========================================================
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIVISOR_RESET = 8'hFF;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // ==========================================================
    // Control field positions
    localparam int CTL_TX_EN = 7;
    localparam int CTL_RX_EN = 6;
    localparam int CTL_INT_EN = 5;
    localparam int CTL_PAR_EN = 4;
    localparam int CTL_PAR_ODD = 3;
    localparam int CTL_SEND_BRK = 2;
    localparam int CTL_STOP2 = 1;
    localparam int CTL_TIMER = 0;
    // ==========================================================
    // Counting constants
    localparam logic [7:0] DIV_RELOAD_AT = 8'h01;
    localparam logic [3:0] PRESC_LAST = 4'hF;
    localparam logic [3:0] PHASE_MID = 4'h7;
    localparam logic [3:0] PHASE_LAST = 4'hF;
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [3:0] FRAME_BITS_BASE = 4'hA;
    localparam logic [3:0] FRAME_BITS_ONE = 4'h1;
    localparam logic [3:0] BIT_ONE = 4'h1;
    // ==========================================================
    // Receiver states, Gray along the frame with parity on; DATA to STOP and STOP to IDLE change two bits
    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_START = 3'h1,
        RX_DATA = 3'h3,
        RX_PARITY = 3'h2,
        RX_STOP = 3'h6
    } urbt_rx_state_t;
endpackage

// file: src/urbt_top.sv
// Serial port receiver, transmit holding logic, baud generator and timer
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Transmit interrupt rises once shifter has sent first bit of a character.
// - Writing transmit data with transmitter enabled clears transmit-ready until shifter has sent that byte's first bit.
// - Writing zero to transmit data clears the pending transmit interrupt.
// - Receive-status bit is one while an unread byte is held.
// - Reception happens only while receiver enable is set.
// - Completed character raises receive interrupt; reading data clears it.
// - Received-data interrupt maskable alone; framing, break and overrun sources stay active.
// - Break is a line held low across data, parity and stop.
// - Break interrupts at once whether empty or not, since its low stop bit is a framing error.
// - Overrun when a character completes while an unread byte is held.
// - Overrun interrupt appears at the data read; the next read clears it.
// - On overrun the new byte is dropped, held byte kept.
// - Framing error when first stop bit samples low; second never checked.
// - Framing error interrupts immediately; reading data clears it.
// - Overrun and the break of an overrunning character stay hidden until the held byte is read.
// - With timer bit set and transmit and receive enables clear, each generator reload raises receive interrupt.
// - Baud generator runs from system clock with 8-bit divisor.
// - Timer ticks at clock/16, counts down, at one interrupts and reloads.
// - In timer mode the divisor register reads the live count.
// - One data address reads received byte and writes byte to send.
// - Reading data clears parity and framing status; it clears overrun and break unless a held-back overrun is revealed.
module urbt_top
    import urbt_pkg::*;
(
    input wire logic core_clk_in, // System clock, 20 MHz
    input wire logic rstn_in, // Asynchronous reset, active low
    input wire logic [7:0] addr_in, // Register address
    input wire logic [7:0] wdata_in, // Register write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    output logic [7:0] rdata_out, // Read data, cycle after strobe
    input wire logic rxd_in, // Serial receive pin
    output logic txd_out, // Serial transmit pin
    output logic tx_irq_out, // Transmit interrupt request
    output logic rx_irq_out // Receive and timer interrupt request
);
    // ==========================================================
    // Register access decode
    logic wr_data, wr_ctrl, wr_div, rd_data;
    assign wr_data = wr_in && (addr_in == OFF_DATA);
    assign wr_ctrl = wr_in && (addr_in == OFF_CONTROL);
    assign wr_div = wr_in && (addr_in == OFF_DIVISOR);
    assign rd_data = rd_in && (addr_in == OFF_DATA);

    logic [7:0] ctrl_ff;
    logic [7:0] divisor_ff;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= wdata_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            divisor_ff <= DIVISOR_RESET;
        end else if (wr_div) begin
            divisor_ff <= wdata_in;
        end
    end

    // ==========================================================
    // Baud generator and timer
    logic timer_mode;
    assign timer_mode = ctrl_ff[CTL_TIMER] && !ctrl_ff[CTL_TX_EN] && !ctrl_ff[CTL_RX_EN];

    logic [3:0] presc_ff;
    logic [7:0] count_ff;
    logic count_step, count_reload, tick16, timer_evt;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            presc_ff <= '0;
        end else begin
            presc_ff <= presc_ff + BIT_ONE;
        end
    end

    // Timer steps on clock/16, baud mode on every clock
    assign count_step = timer_mode ? (presc_ff == PRESC_LAST) : 1'b1;
    assign count_reload = count_step && (count_ff == DIV_RELOAD_AT);
    assign tick16 = !timer_mode && count_reload;
    assign timer_evt = timer_mode && count_reload;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_ff <= DIVISOR_RESET;
        end else if (wr_div) begin
            count_ff <= wdata_in;
        end else if (count_reload) begin
            count_ff <= divisor_ff;
        end else if (count_step) begin
            // Zero wraps to FF, so a zero divisor spans 256 steps
            count_ff <= count_ff - DIV_RELOAD_AT;
        end
    end

    // ==========================================================
    // Receive pin synchroniser
    logic rx_meta_ff, rx_sync_ff, rx_prev_ff;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
            rx_prev_ff <= 1'b1;
        end else begin
            rx_meta_ff <= rxd_in;
            rx_sync_ff <= rx_meta_ff;
            rx_prev_ff <= rx_sync_ff;
        end
    end

    // ==========================================================
    // Receive framing
    urbt_rx_state_t rx_state_ff;
    logic [3:0] rx_phase_ff;
    logic [3:0] rx_bit_ff;
    logic [7:0] rx_shift_ff;
    logic rx_par_ff, rx_zero_ff;
    logic rx_done_ff, rx_fe_ff, rx_pe_ff, rx_brk_ff;
    logic [7:0] rx_byte_ff;
    logic rx_sample;
    assign rx_sample = tick16 && (rx_phase_ff == PHASE_LAST);

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_state_ff <= RX_IDLE;
            rx_phase_ff <= '0;
            rx_bit_ff <= '0;
            rx_shift_ff <= '0;
            rx_par_ff <= 1'b0;
            rx_zero_ff <= 1'b0;
            rx_done_ff <= 1'b0;
            rx_fe_ff <= 1'b0;
            rx_pe_ff <= 1'b0;
            rx_brk_ff <= 1'b0;
            rx_byte_ff <= DATA_RESET;
        end else begin
            rx_done_ff <= 1'b0;
            if (tick16) begin
                rx_phase_ff <= rx_phase_ff + BIT_ONE;
            end
            if (!ctrl_ff[CTL_RX_EN]) begin
                rx_state_ff <= RX_IDLE;
            end else begin
                case (rx_state_ff)
                    RX_IDLE: begin
                        if (rx_prev_ff && !rx_sync_ff) begin
                            rx_phase_ff <= '0;
                            rx_state_ff <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (tick16 && rx_phase_ff == PHASE_MID) begin
                            rx_phase_ff <= '0;
                            rx_bit_ff <= '0;
                            rx_par_ff <= 1'b0;
                            rx_zero_ff <= 1'b1;
                            // A glitch shorter than half a bit is not a start
                            rx_state_ff <= rx_sync_ff ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_sample) begin
                            rx_shift_ff <= {rx_sync_ff, rx_shift_ff[7:1]};
                            rx_par_ff <= rx_par_ff ^ rx_sync_ff;
                            rx_zero_ff <= rx_zero_ff && !rx_sync_ff;
                            rx_bit_ff <= rx_bit_ff + BIT_ONE;
                            if (rx_bit_ff == DATA_LAST) begin
                                rx_state_ff <= ctrl_ff[CTL_PAR_EN] ? RX_PARITY : RX_STOP;
                            end
                        end
                    end
                    RX_PARITY: begin
                        if (rx_sample) begin
                            rx_par_ff <= rx_par_ff ^ rx_sync_ff ^ ctrl_ff[CTL_PAR_ODD];
                            rx_zero_ff <= rx_zero_ff && !rx_sync_ff;
                            rx_state_ff <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rx_sample) begin
                            rx_done_ff <= 1'b1;
                            rx_byte_ff <= rx_shift_ff;
                            rx_fe_ff <= !rx_sync_ff;
                            rx_pe_ff <= ctrl_ff[CTL_PAR_EN] && rx_par_ff;
                            rx_brk_ff <= rx_zero_ff && !rx_sync_ff;
                            // Second stop bit is left unchecked; idle hunts next edge
                            rx_state_ff <= RX_IDLE;
                        end
                    end
                    default: begin
                        rx_state_ff <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Receive data and status
    logic [7:0] rx_data_ff;
    logic rx_full_ff, st_pe_ff, st_ovr_ff, st_fe_ff, st_brk_ff;
    logic hid_ovr_ff, hid_brk_ff;
    logic full_after_read;
    // A read in the same cycle frees the register unless an overrun was held back
    assign full_after_read = rd_data ? hid_ovr_ff : rx_full_ff;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_data_ff <= DATA_RESET;
            rx_full_ff <= 1'b0;
            st_pe_ff <= 1'b0;
            st_ovr_ff <= 1'b0;
            st_fe_ff <= 1'b0;
            st_brk_ff <= 1'b0;
            hid_ovr_ff <= 1'b0;
            hid_brk_ff <= 1'b0;
        end else begin
            if (rd_data) begin
                st_pe_ff <= 1'b0;
                st_fe_ff <= 1'b0;
                if (hid_ovr_ff) begin
                    rx_full_ff <= 1'b1;
                    st_ovr_ff <= 1'b1;
                    st_brk_ff <= hid_brk_ff;
                    hid_ovr_ff <= 1'b0;
                    hid_brk_ff <= 1'b0;
                end else begin
                    rx_full_ff <= 1'b0;
                    st_ovr_ff <= 1'b0;
                    st_brk_ff <= 1'b0;
                end
            end
            // Arrival is applied after the read so a set beats a clear
            if (rx_done_ff) begin
                if (full_after_read) begin
                    hid_ovr_ff <= 1'b1;
                    hid_brk_ff <= (rd_data ? 1'b0 : hid_brk_ff) | rx_brk_ff;
                    if (rx_fe_ff) begin
                        st_fe_ff <= 1'b1;
                    end
                end else begin
                    rx_data_ff <= rx_byte_ff;
                    rx_full_ff <= 1'b1;
                    st_pe_ff <= rx_pe_ff;
                    st_fe_ff <= rx_fe_ff;
                    st_brk_ff <= rx_brk_ff;
                end
            end
        end
    end

    // ==========================================================
    // Receive interrupt request
    logic rx_irq_set;
    assign rx_irq_set = (rx_done_ff && !full_after_read && ctrl_ff[CTL_INT_EN])
        || (rx_done_ff && rx_fe_ff)
        || (rx_done_ff && rx_brk_ff && !full_after_read)
        || (rd_data && hid_ovr_ff)
        || timer_evt;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_irq_out <= 1'b0;
        end else if (rx_irq_set) begin
            rx_irq_out <= 1'b1;
        end else if (rd_data) begin
            rx_irq_out <= 1'b0;
        end
    end

    // ==========================================================
    // Transmit holding register and shifter
    logic [7:0] hold_ff;
    logic hold_full_ff, tx_ready_ff, tx_busy_ff, first_bit_ff;
    logic [11:0] tx_shift_ff;
    logic [3:0] tx_left_ff;
    logic [3:0] tx_phase_ff;
    logic tx_load, tx_bit_end;
    logic [3:0] frame_bits;
    assign tx_load = ctrl_ff[CTL_TX_EN] && hold_full_ff && !tx_busy_ff;
    assign tx_bit_end = tx_busy_ff && tick16 && (tx_phase_ff == PHASE_LAST);
    assign frame_bits = FRAME_BITS_BASE + (ctrl_ff[CTL_PAR_EN] ? FRAME_BITS_ONE : 4'h0)
        + (ctrl_ff[CTL_STOP2] ? FRAME_BITS_ONE : 4'h0);

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hold_ff <= DATA_RESET;
            hold_full_ff <= 1'b0;
        end else if (wr_data && ctrl_ff[CTL_TX_EN]) begin
            // A write while not ready overwrites the waiting byte
            hold_ff <= wdata_in;
            hold_full_ff <= 1'b1;
        end else if (tx_load) begin
            hold_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_busy_ff <= 1'b0;
            first_bit_ff <= 1'b0;
            tx_shift_ff <= '1;
            tx_left_ff <= '0;
            tx_phase_ff <= '0;
        end else if (tx_load) begin
            tx_busy_ff <= 1'b1;
            first_bit_ff <= 1'b1;
            tx_phase_ff <= '0;
            tx_left_ff <= frame_bits;
            tx_shift_ff <= ctrl_ff[CTL_PAR_EN]
                ? {2'b11, ^hold_ff ^ ctrl_ff[CTL_PAR_ODD], hold_ff, 1'b0}
                : {3'b111, hold_ff, 1'b0};
        end else if (tx_busy_ff && tick16) begin
            tx_phase_ff <= tx_phase_ff + BIT_ONE;
            if (tx_bit_end) begin
                first_bit_ff <= 1'b0;
                tx_shift_ff <= {1'b1, tx_shift_ff[11:1]};
                tx_left_ff <= tx_left_ff - BIT_ONE;
                if (tx_left_ff == BIT_ONE) begin
                    tx_busy_ff <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_ready_ff <= 1'b0;
        end else if (wr_data && ctrl_ff[CTL_TX_EN]) begin
            tx_ready_ff <= 1'b0;
        end else if (tx_bit_end && first_bit_ff) begin
            tx_ready_ff <= 1'b1;
        end else if (ctrl_ff[CTL_TX_EN] && !hold_full_ff && !tx_busy_ff) begin
            tx_ready_ff <= 1'b1;
        end
    end

    // Interrupt follows the rising edge of ready, one per character
    logic tx_ready_prev_ff;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tx_ready_prev_ff <= 1'b0;
            tx_irq_out <= 1'b0;
        end else begin
            tx_ready_prev_ff <= tx_ready_ff;
            if (tx_ready_ff && !tx_ready_prev_ff) begin
                tx_irq_out <= 1'b1;
            end else if (wr_data && wdata_in == 8'h00) begin
                tx_irq_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            txd_out <= 1'b1;
        end else begin
            txd_out <= !ctrl_ff[CTL_SEND_BRK] && (!tx_busy_ff || tx_shift_ff[0]);
        end
    end

    // ==========================================================
    // Read data
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                OFF_DATA: rdata_out <= rx_data_ff;
                OFF_STATUS: rdata_out <= {rx_full_ff, st_pe_ff, st_ovr_ff, st_fe_ff,
                    st_brk_ff, tx_ready_ff, !tx_busy_ff && !hold_full_ff, 1'b0};
                OFF_CONTROL: rdata_out <= ctrl_ff;
                OFF_DIVISOR: rdata_out <= timer_mode ? count_ff : divisor_ff;
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end
endmodule // urbt_top

`default_nettype wire
